//--- note_escrow_host.sv
// escrow, host handshake, low power and button modes of a note validator
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - hold one validated note, stack it only after the host confirms the vend
// - on a validated note, give one 100 ms pulse on its channel line
// - host raises escrow to claim; without it within 30 s, return note
// - after escrow goes high, stack and give a second 100 ms pulse
// - channel inhibit raised before timeout returns the escrowed note at once
// - channels above 4 are rejected only when every inhibit is high
// - a note pulled out during escrow puts the unit out of service 45 s
// - sleep about 6 s after power-up, until a note reaches the entry
// - sleep again about 1 s after busy goes high, credit or reject
// - low power only when a non-serial host protocol is selected
// - enabled idle: host holds inhibit low, busy output stays high
// - front sensor wakes the unit, busy low through validation and stacking
// - after stacking, drive vend low for the credit, then release busy
// - config button held 2 s: fast flash, load programming protocol
// - another hold in programming mode restores the former host interface
// - side button held over 3 s: on release, steady flash, trusted mode
// - trusted key-exchange mode lasts 30 s
// - trusted mode entered only by the button, never by a host command
module note_escrow_host
  import note_escrow_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic ESCROW_I,
  input wire logic [NUM_INH-1:0] INHIBIT_I,
  input wire logic CFG_BTN_I,
  input wire logic SIDE_BTN_I,
  input wire logic NOTE_AT_ENTRY_I,
  input wire logic NOTE_VALID_I,
  input wire logic [2:0] NOTE_CH_I,
  input wire logic NOTE_BAD_I,
  input wire logic NOTE_PULLED_I,
  input wire logic NOTE_STACKED_I,
  output logic [NUM_CH-1:0] CHAN_O,
  output logic BUSY_O,
  output logic VEND_N_O,
  output logic LOW_POWER_O,
  output logic STACK_O,
  output logic RETURN_O,
  output logic BEZEL_O,
  output logic PROG_MODE_O,
  output logic TRUSTED_O
);

  state_t st_r, st_nxt;
  pins_t pins_meta_r, pins_s_r, pins_raw;
  logic [16:0] div_r;
  logic [15:0] tmr_r, fl_ms_r, tr_ms_r;
  logic [8:0] bz_cnt_r;
  logic [2:0] ch_r;
  logic [31:0] ctrl_r, prdata_r;
  logic tick, st_change, first_r, prog_r, trusted_r;
  logic [1:0] btn_held, btn_release;
  logic inh_hit, esc_phase, ch_inhibited, tmr_end;
  logic serial_sel, wr_en, rd_setup, hit_ctrl, hit_status;
  logic [31:0] status_w;

  // host pins and buttons come from outside, two flops first
  assign pins_raw = '{escrow: ESCROW_I, inhibit: INHIBIT_I, cfg_btn: CFG_BTN_I,
                      side_btn: SIDE_BTN_I};
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      pins_meta_r <= '0;
      pins_s_r <= '0;
    end
    else if (CE_I)
    begin
      pins_meta_r <= pins_raw;
      pins_s_r <= pins_meta_r;
    end
  end

  // ms divider, restarted on each state change so pulses are exact
  assign st_change = (st_nxt != st_r);
  assign tick = (div_r == 17'(MS_CYCLES - 1));
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || (CE_I && (st_change || tick)))
      div_r <= '0;
    else if (CE_I)
      div_r <= div_r + 17'h00001;
  end

  // ms spent in the current state
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || (CE_I && st_change))
      tmr_r <= '0;
    else if (CE_I && tick && tmr_r != 16'hFFFF)
      tmr_r <= tmr_r + 16'h0001;
  end

  // channel 1..4 have own inhibit, higher ones need all of them
  assign ch_inhibited = (NOTE_CH_I < 3'h4) ? pins_s_r.inhibit[NOTE_CH_I[1:0]]
                                           : &pins_s_r.inhibit;
  assign inh_hit = (ch_r < 3'h4) ? pins_s_r.inhibit[ch_r[1:0]] : &pins_s_r.inhibit;
  assign esc_phase = (st_r == S_PULSE1) || (st_r == S_ESCROW);
  assign serial_sel = ctrl_r[CTRL_SERIAL_BIT];

  // when the current state has run its time
  always_comb
  begin
    tmr_end = 1'b0;
    case (st_r)
      S_IDLE: tmr_end = tick && (tmr_r == (first_r ? PWRUP_TICKS : IDLE_TICKS) - 16'h0001);
      S_PULSE1, S_PULSE2: tmr_end = tick && (tmr_r == PULSE_TICKS - 16'h0001);
      S_ESCROW: tmr_end = tick && (tmr_r == ESCROW_TICKS - 16'h0001);
      S_OOS: tmr_end = tick && (tmr_r == LOCKOUT_TICKS - 16'h0001);
      default: tmr_end = 1'b0;
    endcase
  end

  // handshake sequence; a pulled note outranks inhibit, inhibit outranks claim
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      S_SLEEP:
        if (NOTE_AT_ENTRY_I)
          st_nxt = S_VALIDATE;
        else if (serial_sel)
          st_nxt = S_IDLE;
      S_IDLE:
        if (NOTE_AT_ENTRY_I)
          st_nxt = S_VALIDATE;
        else if (tmr_end && !serial_sel)
          st_nxt = S_SLEEP;
      S_VALIDATE:
        if (NOTE_BAD_I || (NOTE_VALID_I && ch_inhibited))
          st_nxt = S_RETURNING;
        else if (NOTE_VALID_I)
          st_nxt = S_PULSE1;
      S_PULSE1, S_ESCROW:
        if (NOTE_PULLED_I)
          st_nxt = S_OOS;
        else if (inh_hit)
          st_nxt = S_RETURNING;
        else if (st_r == S_PULSE1)
          st_nxt = tmr_end ? S_ESCROW : S_PULSE1;
        else if (pins_s_r.escrow)
          st_nxt = S_STACKING;
        else if (tmr_end)
          st_nxt = S_RETURNING;
      S_STACKING:
        if (NOTE_STACKED_I)
          st_nxt = S_PULSE2;
      S_PULSE2:
        if (tmr_end)
          st_nxt = S_IDLE;
      S_RETURNING:
        if (!NOTE_AT_ENTRY_I)
          st_nxt = S_IDLE;
      S_OOS:
        if (tmr_end)
          st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // state, latched channel, power-up flag
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      st_r <= S_IDLE;
      ch_r <= '0;
      first_r <= 1'b1;
    end
    else if (CE_I)
    begin
      st_r <= st_nxt;
      if (st_r == S_VALIDATE && NOTE_VALID_I)
        ch_r <= NOTE_CH_I;
      if (st_r == S_IDLE && st_change)
        first_r <= 1'b0;
    end
  end

  // host-facing outputs registered from the next state
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      BUSY_O <= 1'b1;
      VEND_N_O <= 1'b1;
      LOW_POWER_O <= 1'b0;
      STACK_O <= 1'b0;
      RETURN_O <= 1'b0;
    end
    else if (CE_I)
    begin
      BUSY_O <= (st_nxt == S_IDLE) || (st_nxt == S_SLEEP);
      VEND_N_O <= !(st_nxt == S_PULSE2);
      LOW_POWER_O <= (st_nxt == S_SLEEP);
      STACK_O <= st_change && (st_nxt == S_STACKING);
      RETURN_O <= st_change && (st_nxt == S_RETURNING);
    end
  end

  // one pulse line per channel, active while in either pulse state
  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_chan
      always_ff @(posedge CLK_I)
      begin
        if (RST_I)
          CHAN_O[i] <= 1'b0;
        else if (CE_I)
          CHAN_O[i] <= ((st_nxt == S_PULSE1) || (st_nxt == S_PULSE2))
                       && (((st_nxt == S_PULSE1) && st_r == S_VALIDATE)
                           ? NOTE_CH_I : ch_r) == 3'(i);
      end
    end
  endgenerate

  // hold timers for config (0) and side (1) buttons; act on release
  generate
    for (genvar b = 0; b < 2; b++)
    begin : g_btn
      logic [15:0] hold_r;
      logic btn;
      logic [15:0] lim;
      assign btn = (b == 0) ? pins_s_r.cfg_btn : pins_s_r.side_btn;
      assign lim = (b == 0) ? PROG_HOLD_TICKS : TRUST_HOLD_TICKS + 16'h0001;
      assign btn_held[b] = (hold_r >= lim);
      assign btn_release[b] = btn_held[b] && !btn;
      always_ff @(posedge CLK_I)
      begin
        if (RST_I || (CE_I && !btn))
          hold_r <= '0;
        else if (CE_I && tick && !btn_held[b])
          hold_r <= hold_r + 16'h0001;
      end
    end
  endgenerate

  // programming, trusted mode and bezel indicator
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      prog_r <= 1'b0;
      trusted_r <= 1'b0;
      fl_ms_r <= '0;
      tr_ms_r <= '0;
      bz_cnt_r <= '0;
    end
    else if (CE_I)
    begin
      if (tick)
        bz_cnt_r <= bz_cnt_r + 9'h001;
      if (btn_release[0])
      begin
        prog_r <= !prog_r;
        fl_ms_r <= prog_r ? 16'h0000 : FLASH_TICKS;
      end
      else if (tick && fl_ms_r != 16'h0000)
        fl_ms_r <= fl_ms_r - 16'h0001;
      // only the physical button reaches this, no bus write does
      if (btn_release[1])
      begin
        trusted_r <= 1'b1;
        tr_ms_r <= TRUST_TICKS;
      end
      else if (tick && tr_ms_r != 16'h0000)
        tr_ms_r <= tr_ms_r - 16'h0001;
      else if (tr_ms_r == 16'h0000)
        trusted_r <= 1'b0;
    end
  end

  // bezel: fast flash after the config release into programming mode, steady blink while trusted
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      BEZEL_O <= 1'b0;
    else if (CE_I)
      BEZEL_O <= (fl_ms_r != 16'h0000) ? bz_cnt_r[FAST_BIT]
               : trusted_r ? bz_cnt_r[SLOW_BIT]
               : (st_r != S_SLEEP);
  end

  assign PROG_MODE_O = prog_r;
  assign TRUSTED_O = trusted_r;

  // apb decode; zero wait states, unmapped answers with an error
  assign hit_ctrl = (PADDR_I == CTRL_OFS);
  assign hit_status = (PADDR_I == STATUS_OFS);
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && hit_ctrl;
  assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !(hit_ctrl || hit_status);
  assign PRDATA_O = prdata_r;

  // status word shows the block's own state
  always_comb
  begin
    status_w = '0;
    status_w[STS_STATE_LSB +: 4] = st_r;
    status_w[STS_CH_LSB +: 3] = ch_r;
    status_w[STS_BUSY_BIT] = BUSY_O;
    status_w[STS_VEND_BIT] = !VEND_N_O;
    status_w[STS_LOWPWR_BIT] = LOW_POWER_O;
    status_w[STS_OOS_BIT] = (st_r == S_OOS);
    status_w[STS_PROG_BIT] = prog_r;
    status_w[STS_TRUST_BIT] = trusted_r;
  end

  // read data latched at setup, stable through the access phase
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ctrl_r <= CTRL_RST;
      prdata_r <= '0;
    end
    else if (CE_I)
    begin
      if (wr_en)
        ctrl_r <= {31'h0000_0000, PWDATA_I[CTRL_SERIAL_BIT]};
      if (rd_setup)
        prdata_r <= hit_ctrl ? ctrl_r : hit_status ? status_w : 32'h0000_0000;
    end
  end

  // checks on the handshake
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  AST_STACK_ONLY_ON_CLAIM: assert property (
    $rose(STACK_O) |-> $past(pins_s_r.escrow) && $past(st_r) == S_ESCROW)
    else $error("stack issued without escrow claim");
  AST_ONE_CHANNEL: assert property (
    $onehot0(CHAN_O))
    else $error("more than one channel line pulsing");
  AST_ESCROW_TIMEOUT: assert property (
    (CE_I && st_r == S_ESCROW && tmr_end && !pins_s_r.escrow && !inh_hit
     && !NOTE_PULLED_I) |=> st_r == S_RETURNING && RETURN_O)
    else $error("escrow timeout did not return the note");
  AST_SECOND_PULSE: assert property (
    (CE_I && st_r == S_STACKING && NOTE_STACKED_I) |=> CHAN_O[ch_r] && !VEND_N_O)
    else $error("no acceptance pulse after stacking");
  AST_INHIBIT_RETURNS: assert property (
    (CE_I && esc_phase && inh_hit && !NOTE_PULLED_I) |=> st_r == S_RETURNING)
    else $error("inhibit did not return escrowed note");
  AST_HIGH_CH_ACCEPT: assert property (
    (CE_I && st_r == S_VALIDATE && NOTE_VALID_I && !NOTE_BAD_I && NOTE_CH_I >= 3'h4
     && !(&pins_s_r.inhibit)) |=> st_r == S_PULSE1)
    else $error("high channel rejected without all inhibits");
  AST_PULLED_OOS: assert property (
    (CE_I && esc_phase && NOTE_PULLED_I) |=> st_r == S_OOS && !BUSY_O)
    else $error("pulled note did not lock out");
  AST_NO_SLEEP_SERIAL: assert property (
    $rose(LOW_POWER_O) |-> !$past(serial_sel))
    else $error("low power entered with serial protocol");
  AST_BUSY_IDLE: assert property (
    BUSY_O == (st_r == S_IDLE || st_r == S_SLEEP))
    else $error("busy output disagrees with idle state");
  AST_VEND_THEN_BUSY: assert property (
    ($rose(BUSY_O) && $past(st_r) == S_PULSE2) |-> $past(!VEND_N_O) && VEND_N_O)
    else $error("busy released without preceding vend");
  AST_TRUST_BY_BUTTON: assert property (
    $rose(trusted_r) |-> $past(btn_release[1]))
    else $error("trusted mode entered without button release");

  COV_STACKED: cover property ((st_r == S_STACKING) ##[1:20] (st_r == S_PULSE2));
  COV_INHIBIT: cover property ((st_r == S_ESCROW) ##1 (st_r == S_RETURNING));
  COV_TRUSTED: cover property ($rose(trusted_r));
  COV_SLEEP: cover property ($rose(LOW_POWER_O));

endmodule // note_escrow_host

`default_nettype wire

//--- note_escrow_pkg.sv
// constants, states and carriers for the note escrow host handshake
package note_escrow_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;

  // documented times, in their own units
  localparam int PULSE_MS = 100;
  localparam int ESCROW_S = 30;
  localparam int LOCKOUT_S = 45;
  localparam int SLEEP_PWRUP_S = 6;
  localparam int SLEEP_IDLE_S = 1;
  localparam int PROG_HOLD_S = 2;
  localparam int TRUST_HOLD_S = 3;
  localparam int TRUST_S = 30;
  localparam int FAST_FLASH_MS = 1000;

  // times as millisecond tick counts
  localparam logic [15:0] PULSE_TICKS = 16'(PULSE_MS);
  localparam logic [15:0] ESCROW_TICKS = 16'(ESCROW_S * MS_PER_S - PULSE_MS);
  localparam logic [15:0] LOCKOUT_TICKS = 16'(LOCKOUT_S * MS_PER_S);
  localparam logic [15:0] PWRUP_TICKS = 16'(SLEEP_PWRUP_S * MS_PER_S);
  localparam logic [15:0] IDLE_TICKS = 16'(SLEEP_IDLE_S * MS_PER_S);
  localparam logic [15:0] PROG_HOLD_TICKS = 16'(PROG_HOLD_S * MS_PER_S);
  localparam logic [15:0] TRUST_HOLD_TICKS = 16'(TRUST_HOLD_S * MS_PER_S);
  localparam logic [15:0] TRUST_TICKS = 16'(TRUST_S * MS_PER_S);
  localparam logic [15:0] FLASH_TICKS = 16'(FAST_FLASH_MS);

  // bezel blink phase bits of the ms counter
  localparam int FAST_BIT = 5;
  localparam int SLOW_BIT = 8;

  // channels and inhibit lines
  localparam int NUM_CH = 8;
  localparam int NUM_INH = 4;

  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_SERIAL_BIT = 0;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CH_LSB = 4;
  localparam int STS_BUSY_BIT = 8;
  localparam int STS_VEND_BIT = 9;
  localparam int STS_LOWPWR_BIT = 10;
  localparam int STS_OOS_BIT = 11;
  localparam int STS_PROG_BIT = 12;
  localparam int STS_TRUST_BIT = 13;

  typedef enum logic [3:0] {
    S_SLEEP, S_IDLE, S_VALIDATE, S_PULSE1, S_ESCROW,
    S_STACKING, S_PULSE2, S_RETURNING, S_OOS
  } state_t;

  // host and panel pins that are synchronised together
  typedef struct packed {
    logic escrow;
    logic [NUM_INH-1:0] inhibit;
    logic cfg_btn;
    logic side_btn;
  } pins_t;

endpackage

//--- host_model.sv
// host machine model driving the escrow claim and inhibit lines
`timescale 1ns/1ps
`default_nettype none
module host_model
  import note_escrow_pkg::*;
#(
  parameter int ABORT_CYC = 100000
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic claim_i,
  input wire logic [NUM_INH-1:0] inh_req_i,
  input wire logic [NUM_CH-1:0] chan_i,
  output logic escrow_o,
  output logic [NUM_INH-1:0] inhibit_o
);
  logic pulse_d_r;
  int wait_r;
  // falling end of any channel pulse
  wire logic pulse_end = pulse_d_r && (chan_i == '0);

  // escrow low while waiting, raised after the first pulse, dropped after the vend
  always_ff @(posedge clk_i)
  begin
    pulse_d_r <= |chan_i;
    inhibit_o <= rst_i ? '0 : inh_req_i; // low in idle, raised to force a return
    wait_r <= escrow_o ? wait_r + 1 : 0;
    if (rst_i)
      escrow_o <= 1'b0; // low while awaiting a note
    else if (!escrow_o && claim_i && pulse_end)
      escrow_o <= 1'b1; // claim the escrowed note
    else if (escrow_o && pulse_end)
      escrow_o <= 1'b0; // vend done, ready for the next note
    else if (escrow_o && wait_r >= ABORT_CYC)
      escrow_o <= 1'b0; // no acceptance pulse in time: vend aborted
  end
endmodule // host_model
`default_nettype wire

//--- tb.sv
// self-checking bench of the note escrow host handshake
`timescale 1ns/1ps
`default_nettype none
module tb;
  import note_escrow_pkg::*;
  // short tick keeps the long counts inside the run budget
  localparam int MS = 4;
  logic clk, rst, psel, penable, pwrite, escrow, claim, cfg_btn, side_btn, perr;
  logic at_entry, valid, pulled, stacked, pready, pslverr, busy, vend_n, low_pwr;
  logic stack, ret, bezel, prog, trusted, bad;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [2:0] ch;
  logic [NUM_INH-1:0] inhibit, inh_req;
  logic [NUM_CH-1:0] chan;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int waited;
  int exp_q[$];

  note_escrow_host #(.MS_CYCLES(MS)) dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .ESCROW_I(escrow), .INHIBIT_I(inhibit), .CFG_BTN_I(cfg_btn), .SIDE_BTN_I(side_btn),
    .NOTE_AT_ENTRY_I(at_entry), .NOTE_VALID_I(valid), .NOTE_CH_I(ch), .NOTE_BAD_I(bad),
    .NOTE_PULLED_I(pulled), .NOTE_STACKED_I(stacked), .CHAN_O(chan), .BUSY_O(busy),
    .VEND_N_O(vend_n), .LOW_POWER_O(low_pwr), .STACK_O(stack), .RETURN_O(ret),
    .BEZEL_O(bezel), .PROG_MODE_O(prog), .TRUSTED_O(trusted));

  host_model #(.ABORT_CYC(ESCROW_S * MS_PER_S * MS)) host (.clk_i(clk), .rst_i(rst),
    .claim_i(claim), .inh_req_i(inh_req), .chan_i(chan), .escrow_o(escrow),
    .inhibit_o(inhibit));

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return busy;
      1: return |chan;
      2: return stack;
      3: return ret;
      default: return low_pwr;
    endcase
  endfunction

  // bounded wait for an output level, edges counted in waited
  task automatic wt(input int s, input logic v);
    waited = 0;
    while (pick(s) !== v && waited < 50000)
    begin
      @(posedge clk);
      waited++;
    end
    chk(pick(s), v);
  endtask

  // level changes of the bezel line over n edges, left in waited
  task automatic bz_count(input int n);
    logic last;
    last = bezel;
    waited = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (bezel !== last)
        waited++;
      last = bezel;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  // one note through the escrow sequence; model decides accept or reject
  task automatic note(input int c, input logic [3:0] inh, input logic clm, input logic pull,
                      input logic bd);
    logic rej;
    rej = bd || ((c < 4) ? inh[c] : (inh == 4'hF));
    if (!rej)
      exp_q.push_back(c);
    @(posedge clk);
    inh_req <= inh;
    claim <= clm;
    repeat (8) @(posedge clk);
    at_entry <= 1'b1;
    wt(0, 1'b0);
    @(posedge clk);
    chk(low_pwr, 1'b0);
    ch <= c[2:0];
    valid <= !bd;
    bad <= bd;
    @(posedge clk);
    valid <= 1'b0;
    bad <= 1'b0;
    at_entry <= rej; // an accepted note has left the entry sensor
    if (rej)
    begin
      wt(3, 1'b1);
      chk(chan, '0);
    end
    else
    begin
      wt(1, 1'b1);
      chk(chan, 32'(1 << exp_q.pop_front()));
      wt(1, 1'b0);
      chk(waited, PULSE_TICKS * MS);
      // the host claims right at pulse end; a delay here would miss the stack pulse
      if (pull || !clm)
        repeat (10) @(posedge clk);
      if (pull)
      begin
        pulled <= 1'b1;
        @(posedge clk);
        pulled <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, STATUS_OFS, '0);
        chk(rd[STS_OOS_BIT], 1'b1);
      end
      else if (!clm)
      begin
        inh_req <= 4'(1 << c);
        wt(3, 1'b1);
        chk(32'(waited < 12), 1);
      end
      else
      begin
        wt(2, 1'b1);
        chk(escrow, 1'b1);
        stacked <= 1'b1;
        @(posedge clk);
        stacked <= 1'b0;
        wt(1, 1'b1);
        chk({busy, vend_n, chan}, {2'b00, 8'(1 << c)});
        wt(0, 1'b1);
        chk({vend_n, chan}, 9'h100);
      end
    end
    at_entry <= 1'b0;
    inh_req <= '0;
    $display("note test on channel %0d done", c);
  endtask

  // cut a hung run short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, claim, cfg_btn, side_btn, at_entry, valid, pulled, stacked, bad} = '0;
    paddr = '0;
    pwdata = '0;
    ch = '0;
    inh_req = '0;
    rnd = 32'h06E1;
    do_reset();
    chk(busy, 1'b1);
    wt(4, 1'b1);
    chk(32'(waited > PWRUP_TICKS * MS - 8 && waited < PWRUP_TICKS * MS + 8), 1);
    apb(1'b0, CTRL_OFS, '0);
    chk(rd, CTRL_RST);
    apb(1'b0, 8'h08, '0);
    chk(perr, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("power-up and register test done");
    rnd = lfsr(rnd);
    note(int'(rnd[1:0]), 4'h0, 1'b1, 1'b0, 1'b0);
    wt(4, 1'b1);
    chk(32'(waited > IDLE_TICKS * MS - 8 && waited < IDLE_TICKS * MS + 8), 1);
    note(5, 4'h7, 1'b1, 1'b0, 1'b0);
    note(5, 4'hF, 1'b1, 1'b0, 1'b0);
    rnd = lfsr(rnd);
    note(int'(rnd[1:0]), 4'h0, 1'b1, 1'b0, 1'b1);
    wt(4, 1'b1);
    chk(32'(waited > IDLE_TICKS * MS - 8 && waited < IDLE_TICKS * MS + 8), 1);
    rnd = lfsr(rnd);
    note(int'(rnd[1:0]), 4'(1 << rnd[1:0]), 1'b1, 1'b0, 1'b0);
    rnd = lfsr(rnd);
    note(int'(rnd[1:0]), 4'h0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, CTRL_OFS, '0);
    chk(rd, 32'h0000_0001);
    chk(trusted, 1'b0);
    note(6, 4'h0, 1'b1, 1'b0, 1'b0);
    repeat (IDLE_TICKS * MS + 40) @(posedge clk);
    chk(low_pwr, 1'b0);
    $display("serial selection test done");
    for (int i = 0; i < 2; i++)
    begin
      cfg_btn <= 1'b1;
      repeat (PROG_HOLD_TICKS * MS + 40) @(posedge clk);
      cfg_btn <= 1'b0;
      repeat (20) @(posedge clk);
      chk(prog, 1'(i == 0));
      bz_count(400);
      chk(32'(i == 0 ? waited >= 2 : waited == 0), 1);
    end
    side_btn <= 1'b1;
    repeat (TRUST_HOLD_TICKS * MS + 40) @(posedge clk);
    side_btn <= 1'b0;
    repeat (400) @(posedge clk);
    chk(trusted, 1'b1);
    bz_count(2100);
    chk(32'(waited >= 2), 1);
    $display("button test done");
    rnd = lfsr(rnd);
    note(int'(rnd[1:0]), 4'h0, 1'b0, 1'b1, 1'b0);
    do_reset();
    chk(busy, 1'b1);
    finish_test();
  end
endmodule // tb
`default_nettype wire
